// >>> include/strap_pkg.sv
// Purpose: shared constants for the strap configuration latch
// Assumes: 16-bit management words, word-indexed register port
// Notes:   pin indices select bits of the strap pin vectors
package strap_pkg;

  // strap pin positions within the pin vectors
  localparam int STRAP_PIN_COUNT = 13;
  localparam int PIN_ADDR0       = 0;
  localparam int PIN_ADDR1       = 1;
  localparam int PIN_ADDR2       = 2;
  localparam int PIN_MODE0       = 3;
  localparam int PIN_MODE1       = 4;
  localparam int PIN_MODE2       = 5;
  localparam int PIN_WAKE        = 6;
  localparam int PIN_ISOLATE     = 7;
  localparam int PIN_SPEED       = 8;
  localparam int PIN_DUPLEX      = 9;
  localparam int PIN_AUTONEG     = 10;
  localparam int PIN_UNIQUE0     = 11;
  localparam int PIN_GATE_TEST   = 12;

  // register word indices
  localparam logic [4:0] CTRL_IDX   = 5'h00;
  localparam logic [4:0] ADV_IDX    = 5'h04;
  localparam logic [4:0] SPEC_IDX   = 5'h16;
  localparam logic [4:0] STATUS_IDX = 5'h18;

  // control word bit positions
  localparam int CTRL_SPEED_BIT   = 13;
  localparam int CTRL_AUTONEG_BIT = 12;
  localparam int CTRL_ISOLATE_BIT = 10;
  localparam int CTRL_DUPLEX_BIT  = 8;

  // special word bit positions
  localparam int SPEC_WAKE_BIT    = 15;
  localparam int SPEC_UNIQUE0_BIT = 9;

  // reset values before the straps are taken
  localparam logic [15:0] CTRL_RST     = 16'h3100;
  localparam logic [15:0] ADV_RST      = 16'h01E1;
  localparam logic [15:0] SPEC_RST     = 16'h0000;
  localparam logic [15:0] ADV_100_MASK = 16'h0180;

  // interface mode codes and address layout
  localparam logic [2:0] MODE_NORMAL  = 3'b001;
  localparam logic [2:0] MODE_B2B     = 3'b101;
  localparam logic [1:0] ADDR_UPPER   = 2'b00;
  localparam logic [2:0] ADDR_DEFAULT = 3'b001;

endpackage : strap_pkg

// >>> src/cfg_word_reg.sv
// Purpose: one 16-bit configuration word with strap load and software write
// Assumes: load and write never meet outside the single capture cycle
// Notes:   load wins over write in that cycle
`timescale 1ns/1ps
module cfg_word_reg #(
  parameter logic [15:0] RST_VAL = 16'h0000
) (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        load_en,
  input  wire logic [15:0] load_val,
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  output logic      [15:0] word_q
);

  logic [15:0] word_d;

  // next value: strap load, then software write
  always_comb begin
    word_d = word_q;
    if (load_en) begin
      word_d = load_val;
    end else if (wr_en) begin
      word_d = wr_data;
    end
  end

  // word storage
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      word_q <= RST_VAL;
    end else begin
      word_q <= word_d;
    end
  end

endmodule : cfg_word_reg

// >>> src/phy_strap_config_latch.sv
// Purpose: capture board straps once after reset and hold them as configuration
// Assumes: pins are synchronous to ref_clk; sys_rst is synchronous, active high
// Notes:   register port is word indexed; read data follow one cycle later
`timescale 1ns/1ps
module phy_strap_config_latch (
  input  wire logic                                  ref_clk,
  input  wire logic                                  sys_rst,
  input  wire logic [strap_pkg::STRAP_PIN_COUNT-1:0] strap_pin_in,
  output logic      [strap_pkg::STRAP_PIN_COUNT-1:0] strap_pin_out,
  output logic      [strap_pkg::STRAP_PIN_COUNT-1:0] strap_pin_oe,
  input  wire logic [strap_pkg::STRAP_PIN_COUNT-1:0] func_out,
  input  wire logic [4:0]                            reg_addr,
  input  wire logic [15:0]                           reg_wdata,
  input  wire logic                                  reg_wr,
  input  wire logic                                  reg_rd,
  output logic      [15:0]                           reg_rdata,
  output logic      [4:0]                            mgmt_addr,
  output logic                                       bcast_addr_en,
  output logic                                       mode_normal,
  output logic                                       mode_b2b,
  output logic                                       mode_reserved,
  output logic                                       speed_100,
  output logic                                       autoneg_en,
  output logic                                       isolate_en,
  output logic                                       half_duplex,
  output logic                                       wake_out_en,
  output logic                                       gate_test_en,
  output logic                                       config_valid
);
  import strap_pkg::*;

  typedef enum logic {
    PH_SAMPLE = 1'b0,
    PH_RUN    = 1'b1
  } phase_type;

  phase_type   phase_q;
  phase_type   phase_d;
  logic        capture;
  logic [2:0]  addr_q;
  logic [2:0]  addr_d;
  logic [2:0]  mode_q;
  logic [2:0]  mode_d;
  logic        normal_q;
  logic        normal_d;
  logic        b2b_q;
  logic        b2b_d;
  logic        test_q;
  logic        test_d;
  logic [15:0] ctrl_q;
  logic [15:0] adv_q;
  logic [15:0] spec_q;
  logic [15:0] ctrl_load;
  logic [15:0] adv_load;
  logic [15:0] spec_load;
  logic        ctrl_wr;
  logic        adv_wr;
  logic        spec_wr;
  logic [15:0] rdata_d;
  logic [15:0] rdata_q;

  // address hit for one word, used by writes and reads
  function automatic logic word_hit(input logic [4:0] addr, input logic [4:0] idx);
    word_hit = (addr == idx);
  endfunction : word_hit

  // single capture cycle
  // the first cycle out of reset is the only one in the sample phase
  assign capture = (phase_q == PH_SAMPLE);

  // phase sequencing
  always_comb begin
    phase_d = phase_q;
    unique case (phase_q)
      PH_SAMPLE: begin
        phase_d = PH_RUN;
      end
      PH_RUN: begin
        phase_d = PH_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      phase_q <= PH_SAMPLE;
    end else begin
      phase_q <= phase_d;
    end
  end

  // mode decode at capture
  // latched straps kept outside the register words
  always_comb begin
    addr_d   = addr_q;
    mode_d   = mode_q;
    normal_d = normal_q;
    b2b_d    = b2b_q;
    test_d   = test_q;
    if (capture) begin
      addr_d   = {strap_pin_in[PIN_ADDR2], strap_pin_in[PIN_ADDR1], strap_pin_in[PIN_ADDR0]};
      mode_d   = {strap_pin_in[PIN_MODE2], strap_pin_in[PIN_MODE1], strap_pin_in[PIN_MODE0]};
      normal_d = (mode_d == MODE_NORMAL);
      b2b_d    = (mode_d == MODE_B2B);
      test_d   = ~strap_pin_in[PIN_GATE_TEST];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      addr_q   <= ADDR_DEFAULT;
      mode_q   <= MODE_NORMAL;
      normal_q <= 1'b1;
      b2b_q    <= 1'b0;
      test_q   <= 1'b0;
    end else begin
      addr_q   <= addr_d;
      mode_q   <= mode_d;
      normal_q <= normal_d;
      b2b_q    <= b2b_d;
      test_q   <= test_d;
    end
  end

  // strap images for the three register words
  always_comb begin
    ctrl_load = CTRL_RST;
    adv_load  = ADV_RST;
    spec_load = SPEC_RST;
    ctrl_load[CTRL_SPEED_BIT] = strap_pin_in[PIN_SPEED];
    if (!strap_pin_in[PIN_SPEED]) begin
      adv_load = ADV_RST & ~ADV_100_MASK;
    end
    ctrl_load[CTRL_AUTONEG_BIT] = strap_pin_in[PIN_AUTONEG];
    ctrl_load[CTRL_ISOLATE_BIT] = strap_pin_in[PIN_ISOLATE];
    ctrl_load[CTRL_DUPLEX_BIT] = strap_pin_in[PIN_DUPLEX];
    spec_load[SPEC_WAKE_BIT] = strap_pin_in[PIN_WAKE];
    spec_load[SPEC_UNIQUE0_BIT] = strap_pin_in[PIN_UNIQUE0];
  end

  assign ctrl_wr = reg_wr && word_hit(reg_addr, CTRL_IDX);
  assign adv_wr  = reg_wr && word_hit(reg_addr, ADV_IDX);
  assign spec_wr = reg_wr && word_hit(reg_addr, SPEC_IDX);

  // words loaded only in capture cycle
  cfg_word_reg #(
    .RST_VAL (CTRL_RST)
  ) u_ctrl_word (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .load_en  (capture),
    .load_val (ctrl_load),
    .wr_en    (ctrl_wr),
    .wr_data  (reg_wdata),
    .word_q   (ctrl_q)
  );

  cfg_word_reg #(
    .RST_VAL (ADV_RST)
  ) u_adv_word (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .load_en  (capture),
    .load_val (adv_load),
    .wr_en    (adv_wr),
    .wr_data  (reg_wdata),
    .word_q   (adv_q)
  );

  cfg_word_reg #(
    .RST_VAL (SPEC_RST)
  ) u_spec_word (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .load_en  (capture),
    .load_val (spec_load),
    .wr_en    (spec_wr),
    .wr_data  (reg_wdata),
    .word_q   (spec_q)
  );

  // read mux, unmapped words read zero
  always_comb begin
    rdata_d = 16'h0000;
    if (reg_rd) begin
      if (word_hit(reg_addr, CTRL_IDX)) begin
        rdata_d = ctrl_q;
      end else if (word_hit(reg_addr, ADV_IDX)) begin
        rdata_d = adv_q;
      end else if (word_hit(reg_addr, SPEC_IDX)) begin
        rdata_d = spec_q;
      end else if (word_hit(reg_addr, STATUS_IDX)) begin
        rdata_d = {2'b00, b2b_q, normal_q, test_q, bcast_addr_en, mode_q, config_valid,
                   1'b0, mgmt_addr};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  assign mgmt_addr     = {ADDR_UPPER, addr_q};
  // broadcast while the special word unique bit is clear, whether strap-loaded or last written
  assign bcast_addr_en = ~spec_q[SPEC_UNIQUE0_BIT];
  assign mode_normal   = normal_q;
  assign mode_b2b      = b2b_q;
  assign mode_reserved = ~normal_q & ~b2b_q;
  assign speed_100     = ctrl_q[CTRL_SPEED_BIT];
  assign autoneg_en    = ctrl_q[CTRL_AUTONEG_BIT];
  assign isolate_en    = ctrl_q[CTRL_ISOLATE_BIT];
  assign half_duplex   = ctrl_q[CTRL_DUPLEX_BIT];
  assign wake_out_en   = spec_q[SPEC_WAKE_BIT];
  assign gate_test_en  = test_q;
  assign config_valid  = (phase_q == PH_RUN);

  genvar gi;
  generate
    for (gi = 0; gi < STRAP_PIN_COUNT; gi++) begin : g_pin
      assign strap_pin_oe[gi]  = (phase_q == PH_RUN);
      assign strap_pin_out[gi] = (phase_q == PH_RUN) & func_out[gi];
    end
  endgenerate

  // checks on the capture and hold behaviour
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_capture;
    phase_q == PH_SAMPLE;
  endsequence

  sequence s_no_write;
    !reg_wr;
  endsequence

  a_capture_once: assert property (config_valid |=> config_valid && !capture)
    else $error("straps taken again after capture");

  a_addr_strapped: assert property (s_capture |=> mgmt_addr[2:0] == $past(strap_pin_in[2:0]))
    else $error("address straps not latched");

  a_addr_upper: assert property (s_capture ##1 1'b1 |-> mgmt_addr[4:3] == 2'b00 [*3])
    else $error("upper address bits not zero");

  a_bcast_strap: assert property (s_capture |=> bcast_addr_en == !$past(strap_pin_in[11]))
    else $error("broadcast enable does not follow strap");

  a_bcast_write: assert property (config_valid && spec_wr |=> bcast_addr_en == !$past(reg_wdata[9]))
    else $error("broadcast enable does not follow write");

  a_mode_decode: assert property (s_capture |=> mode_b2b == ($past(strap_pin_in[5:3]) == 3'b101)
                                  && mode_normal == ($past(strap_pin_in[5:3]) == 3'b001))
    else $error("mode decode wrong");

  a_wake_strap: assert property (s_capture |=> wake_out_en == $past(strap_pin_in[6]))
    else $error("wake strap not in bit 15");

  a_isolate_strap: assert property (s_capture |=> ctrl_q[10] == $past(strap_pin_in[7]))
    else $error("isolate strap not in bit 10");

  a_speed_strap: assert property (s_capture |=> ctrl_q[13] == $past(strap_pin_in[8])
                                  && adv_q[8:7] == {2{$past(strap_pin_in[8])}})
    else $error("speed strap not applied");

  a_duplex_strap: assert property (s_capture |=> half_duplex == $past(strap_pin_in[9]))
    else $error("duplex strap not in bit 8");

  a_autoneg_strap: assert property (s_capture |=> autoneg_en == $past(strap_pin_in[10]))
    else $error("negotiation strap not in bit 12");

  a_test_strap: assert property (s_capture |=> gate_test_en == !$past(strap_pin_in[PIN_GATE_TEST]))
    else $error("test strap not latched low active");

  a_pin_turn: assert property (s_capture |-> strap_pin_oe == '0 ##1 strap_pin_oe == '1)
    else $error("strap pins not turned to outputs");

  a_hold_cfg: assert property (config_valid ##0 s_no_write |=> $stable(ctrl_q) && $stable(spec_q)
                               && $stable(adv_q))
    else $error("configuration changed without write");

  sequence s_running;
    config_valid;
  endsequence

  a_ctrl_write: assert property (s_running ##0 ctrl_wr |=> ctrl_q == $past(reg_wdata))
    else $error("control word write lost");

  a_spec_write: assert property (s_running ##0 spec_wr |=> spec_q == $past(reg_wdata))
    else $error("special word write lost");

  a_adv_write: assert property (s_running ##0 adv_wr |=> adv_q == $past(reg_wdata))
    else $error("advertisement write lost");

  a_strap_hold: assert property (s_running |=> $stable(mgmt_addr) && $stable(mode_q)
                                 && $stable(gate_test_en))
    else $error("latched straps changed after capture");

  a_mode_reserved: assert property (s_capture |=> mode_reserved == ($past(strap_pin_in[5:3]) != 3'b001
                                    && $past(strap_pin_in[5:3]) != 3'b101))
    else $error("reserved mode flag wrong");

  a_pin_drive: assert property (s_running |-> strap_pin_out == func_out)
    else $error("strap pins do not carry their function");

  a_pin_quiet: assert property (s_capture |-> strap_pin_out == '0)
    else $error("strap pins driven during capture");

  a_read_ctrl: assert property (reg_rd && word_hit(reg_addr, CTRL_IDX)
                                |=> reg_rdata == $past(ctrl_q))
    else $error("control word read wrong");

endmodule : phy_strap_config_latch

// >>> sim/strap_board_model.sv
// Purpose: board strap resistors and pin wiring around the strap latch
// Assumes: one strap resistor per pin, stronger than the internal pulls
// Notes:   a released pin settles to its resistor level, never to the last drive
`timescale 1ns/1ps
module strap_board_model (
  input  wire logic [12:0] pull_level,
  input  wire logic [12:0] pin_out,
  input  wire logic [12:0] pin_oe,
  output logic      [12:0] pin_level
);
  always_comb begin
    for (int i = 0; i < 13; i++) begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : pull_level[i];
    end
  end
endmodule : strap_board_model

// >>> sim/phy_strap_config_latch_tb_top.sv
// Purpose: self-checking bench for the strap configuration latch
// Assumes: strap levels come from the board model; 100 ns clock
// Notes:   table rows cover all eight mode codes and every strap level
`timescale 1ns/1ps
module phy_strap_config_latch_tb_top;
  import strap_pkg::*;
  typedef struct packed {
    logic [12:0] pins;
    logic [4:0]  addr;
    logic        normal;
    logic        b2b;
  } row_type;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [12:0] pull_level = 13'h1709;
  logic [12:0] func_out = 13'h0000;
  logic [12:0] pin_level;
  logic [12:0] strap_pin_out;
  logic [12:0] strap_pin_oe;
  logic [4:0]  reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [4:0]  mgmt_addr;
  logic        bcast_addr_en, mode_normal, mode_b2b, mode_reserved, speed_100, autoneg_en;
  logic        isolate_en, half_duplex, wake_out_en, gate_test_en, config_valid;
  int          errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  row_type     rows [8];
  // clock, 100 ns period
  always #50 ref_clk = ~ref_clk;
  strap_board_model board (.pull_level(pull_level), .pin_out(strap_pin_out), .pin_oe(strap_pin_oe),
                           .pin_level(pin_level));
  phy_strap_config_latch dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .strap_pin_in(pin_level), .strap_pin_out(strap_pin_out),
    .strap_pin_oe(strap_pin_oe), .func_out(func_out), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mgmt_addr(mgmt_addr),
    .bcast_addr_en(bcast_addr_en), .mode_normal(mode_normal), .mode_b2b(mode_b2b),
    .mode_reserved(mode_reserved), .speed_100(speed_100), .autoneg_en(autoneg_en),
    .isolate_en(isolate_en), .half_duplex(half_duplex), .wake_out_en(wake_out_en),
    .gate_test_en(gate_test_en), .config_valid(config_valid));
  // control word expected from the strap levels
  function automatic logic [15:0] exp_ctrl(input logic [12:0] p);
    exp_ctrl = {2'b00, p[8], p[10], 1'b0, p[7], 1'b0, p[9], 8'h00};
  endfunction : exp_ctrl
  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize
  // one comparison
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // register write, one strobe cycle
  task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : reg_write
  // register read, data checked in the cycle after the strobe
  task automatic reg_check(input logic [4:0] a, input logic [15:0] exp, input string what);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask : reg_check
  // reset with wrong levels first, right levels just before release
  task automatic strap_reset(input logic [12:0] p, input int hold);
    @(posedge ref_clk);
    sys_rst    <= 1'b1;
    pull_level <= ~p;
    repeat (hold - 2) @(posedge ref_clk);
    pull_level <= p;
    @(posedge ref_clk);
    #1;
    chk("enable in reset", 16'h0000, {3'h0, strap_pin_oe});
    chk("drive in reset", 16'h0000, {3'h0, strap_pin_out});
    chk("valid in reset", 16'h0000, {15'h0, config_valid});
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : strap_reset
  // timeout guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    rows[0] = '{13'h1709, 5'h01, 1'b1, 1'b0};
    rows[1] = '{13'h08E8, 5'h00, 1'b0, 1'b1};
    rows[2] = '{13'h1007, 5'h07, 1'b0, 1'b0};
    rows[3] = '{13'h0112, 5'h02, 1'b0, 1'b0};
    rows[4] = '{13'h121B, 5'h03, 1'b0, 1'b0};
    rows[5] = '{13'h0424, 5'h04, 1'b0, 1'b0};
    rows[6] = '{13'h1875, 5'h05, 1'b0, 1'b0};
    rows[7] = '{13'h00BE, 5'h06, 1'b0, 1'b0};
    strap_reset(13'h1709, 5);
    // table: capture, then pins turn to outputs and must not reload
    foreach (rows[i]) begin
      strap_reset(rows[i].pins, 3);
      @(posedge ref_clk);
      pull_level <= ~rows[i].pins;
      func_out   <= 13'h1A5A ^ rows[i].pins;
      repeat (2) @(posedge ref_clk);
      #1;
      chk("address", {11'h0, rows[i].addr}, {11'h0, mgmt_addr});
      chk("modes", {13'h0, rows[i].normal, rows[i].b2b, ~(rows[i].normal | rows[i].b2b)},
          {13'h0, mode_normal, mode_b2b, mode_reserved});
      chk("control bits", exp_ctrl(rows[i].pins), {2'b00, speed_100, autoneg_en, 1'b0, isolate_en,
          1'b0, half_duplex, 8'h00});
      chk("flags", {13'h0, ~rows[i].pins[11], rows[i].pins[6], ~rows[i].pins[12]},
          {13'h0, bcast_addr_en, wake_out_en, gate_test_en});
      chk("pin drive", {3'h0, 13'h1A5A ^ rows[i].pins}, {3'h0, strap_pin_out});
      chk("pin enable", 16'h1FFF, {3'h0, strap_pin_oe});
      reg_check(CTRL_IDX, exp_ctrl(rows[i].pins), "control word");
      reg_check(ADV_IDX, rows[i].pins[8] ? 16'h01E1 : 16'h0061, "advert word");
      reg_check(SPEC_IDX, {rows[i].pins[6], 5'h00, rows[i].pins[11], 9'h000}, "special word");
    end
    // software overrides of strap-loaded bits
    strap_reset(13'h1709, 3);
    reg_write(SPEC_IDX, 16'h0200);
    chk("broadcast off", 16'h0000, {15'h0, bcast_addr_en});
    reg_write(SPEC_IDX, 16'h8000);
    chk("broadcast and wake", 16'h0003, {14'h0, bcast_addr_en, wake_out_en});
    reg_write(CTRL_IDX, 16'h0000);
    chk("control rewrite", 16'h0000, {12'h0, speed_100, autoneg_en, isolate_en, half_duplex});
    reg_write(ADV_IDX, 16'h0061);
    reg_check(ADV_IDX, 16'h0061, "advert rewrite");
    // read-only and unmapped places, reads one idle cycle apart
    reg_write(STATUS_IDX, 16'hFFFF);
    reg_check(STATUS_IDX, 16'h14C1, "status word");
    reg_write(5'h05, 16'hFFFF);
    reg_check(5'h05, 16'h0000, "unmapped word");
    reg_check(SPEC_IDX, 16'h8000, "special word");
    @(posedge ref_clk);
    #1;
    chk("read data idle", 16'h0000, reg_rdata);
    summarize();
  end
endmodule : phy_strap_config_latch_tb_top
